// [design/cmpskp_core.sv]
// What this block does
// - Decode skip-if-equal compare opcode.
// - Decode skip-if-greater compare opcode.
// - Decode skip-if-less compare opcode.
// - Compare by unsigned subtraction, file minus working.
// - True condition discards next, inserts one nop.
// - Skipped two-word instruction inserts two nops.
// - Operand bit selects fast bank or bank register.
// - One word, eight-bit file address operand.
`timescale 1ns/1ps
`default_nettype none

module cmpskp_core (
   // Clock and reset.
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   // Instruction from the fetch pipeline.
   input  wire logic                          instr_valid,
   input  wire logic [cmpskp_pkg::WORD_W-1:0] instr_word,
   output logic                               instr_ready,
   output logic                               cmp_hit,
   input  wire logic                          next_two_word,
   // Core state.
   input  wire logic [cmpskp_pkg::DATA_W-1:0] working_register,
   input  wire logic [cmpskp_pkg::BANK_W-1:0] bank_select_register,
   // Data memory read port.
   output logic                               mem_rd_en,
   output logic [cmpskp_pkg::ADDR_W-1:0]      mem_rd_addr,
   input  wire logic [cmpskp_pkg::DATA_W-1:0] mem_rd_data,
   // Sequencing results.
   output logic                               skip_discard,
   output logic                               nop_cycle,
   output logic                               cmp_done,
   output logic [1:0]                         cmp_cycles,
   output logic [cmpskp_pkg::DATA_W-1:0]      cmp_diff
);
   import cmpskp_pkg::*;

   // ************************************************************
   // Decode.
   // ************************************************************
   cmpskp_dec_if dec ();

   assign dec.word = instr_word;

   cmpskp_decode u_decode (
      .dec (dec)
   );

   // ************************************************************
   // Sequencer state.
   // ************************************************************
   // Instruction held while it runs.
   cmpskp_state_e          state_q;
   cmpskp_state_e          state_d;
   cmpskp_op_e             op_q;
   cmpskp_op_e             op_d;
   logic                   two_q;
   logic                   two_d;

   // Registered results toward the datapath.
   logic                   rd_en_q;
   logic                   rd_en_d;
   logic [ADDR_W-1:0]      addr_q;
   logic [ADDR_W-1:0]      addr_d;
   logic                   skip_q;
   logic                   skip_d;
   logic                   nop_q;
   logic                   nop_d;
   logic                   done_q;
   logic                   done_d;
   logic [1:0]             cycles_q;
   logic [1:0]             cycles_d;
   logic [DATA_W-1:0]      diff_q;
   logic [DATA_W-1:0]      diff_d;

   // ************************************************************
   // Compare datapath.
   // ************************************************************
   logic [DATA_W:0] sub_ext;
   logic            is_equal;
   logic            is_less;
   logic            is_greater;
   logic            cond_true;
   logic            accept;

   // Nine-bit subtraction keeps the borrow as the unsigned less flag.
   assign sub_ext    = {1'b0, mem_rd_data} - {1'b0, working_register};
   assign is_equal   = (sub_ext[DATA_W-1:0] == '0);
   assign is_less    = sub_ext[DATA_W];
   assign is_greater = !is_less && !is_equal;

   // ************************************************************
   // Condition select.
   // ************************************************************

   always_comb begin
      case (op_q)
         CMPSKP_OP_EQUAL:   cond_true = is_equal;
         CMPSKP_OP_GREATER: cond_true = is_greater;
         CMPSKP_OP_LESS:    cond_true = is_less;
         default:           cond_true = 1'b0;
      endcase
   end

   // ************************************************************
   // Handshake.
   // ************************************************************
   // A word that is not a compare never leaves the idle state.
   assign instr_ready = (state_q == CMPSKP_ST_IDLE);
   assign cmp_hit     = instr_valid && (dec.op != CMPSKP_OP_NONE);
   assign accept      = instr_ready && cmp_hit;

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      state_d  = state_q;
      op_d     = op_q;
      two_d    = two_q;
      rd_en_d  = 1'b0;
      addr_d   = addr_q;
      skip_d   = 1'b0;
      nop_d    = 1'b0;
      done_d   = 1'b0;
      cycles_d = cycles_q;
      diff_d   = diff_q;
      case (state_q)
         CMPSKP_ST_IDLE: begin
            if (accept) begin
               // Operation and bank choice are frozen at the accepting edge.
               op_d    = dec.op;
               rd_en_d = 1'b1;
               addr_d  = cmpskp_map_addr(dec.a_bit, dec.file_addr,
                                         bank_select_register);
               state_d = CMPSKP_ST_READ;
            end
         end
         CMPSKP_ST_READ: begin
            // Only a difference is kept; nothing is written back.
            diff_d = sub_ext[DATA_W-1:0];
            // The length of the following word is known only once it is fetched.
            two_d  = next_two_word;
            if (cond_true) begin
               skip_d  = 1'b1;
               nop_d   = 1'b1;
               state_d = CMPSKP_ST_NOP1;
            end else begin
               done_d   = 1'b1;
               cycles_d = CYC_NO_SKIP;
               state_d  = CMPSKP_ST_IDLE;
            end
         end
         CMPSKP_ST_NOP1: begin
            // A two-word successor needs a second empty cycle.
            if (two_q) begin
               nop_d   = 1'b1;
               state_d = CMPSKP_ST_NOP2;
            end else begin
               done_d   = 1'b1;
               cycles_d = CYC_SKIP;
               state_d  = CMPSKP_ST_IDLE;
            end
         end
         CMPSKP_ST_NOP2: begin
            // Second empty cycle done; the instruction ends here.
            done_d   = 1'b1;
            cycles_d = CYC_SKIP_TWO;
            state_d  = CMPSKP_ST_IDLE;
         end
         default: begin
            state_d = CMPSKP_ST_IDLE;
         end
      endcase
   end

   // ************************************************************
   // Registers.
   // ************************************************************
   // Every result clears so that no stale pulse follows a reset.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q  <= CMPSKP_ST_IDLE;
         op_q     <= CMPSKP_OP_NONE;
         two_q    <= 1'b0;
         rd_en_q  <= 1'b0;
         addr_q   <= '0;
         skip_q   <= 1'b0;
         nop_q    <= 1'b0;
         done_q   <= 1'b0;
         cycles_q <= '0;
         diff_q   <= '0;
      end else begin
         state_q  <= state_d;
         op_q     <= op_d;
         two_q    <= two_d;
         rd_en_q  <= rd_en_d;
         addr_q   <= addr_d;
         skip_q   <= skip_d;
         nop_q    <= nop_d;
         done_q   <= done_d;
         cycles_q <= cycles_d;
         diff_q   <= diff_d;
      end
   end

   // ************************************************************
   // Outputs.
   // ************************************************************
   // Every output below comes straight from a flip-flop.
   assign mem_rd_en    = rd_en_q;
   assign mem_rd_addr  = addr_q;
   assign skip_discard = skip_q;
   assign nop_cycle    = nop_q;
   assign cmp_done     = done_q;
   assign cmp_cycles   = cycles_q;
   assign cmp_diff     = diff_q;

endmodule : cmpskp_core

`default_nettype wire

// [inc/cmpskp_pkg.sv]
package cmpskp_pkg;

   // ************************************************************
   // Opcode fields.
   // ************************************************************
   localparam int unsigned OPC_MSB       = 15;
   localparam int unsigned OPC_LSB       = 9;
   localparam int unsigned ABIT_POS      = 8;
   localparam int unsigned FILE_MSB      = 7;
   localparam int unsigned FILE_W        = 8;
   localparam int unsigned BANK_W        = 4;
   localparam int unsigned ADDR_W        = BANK_W + FILE_W;
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned DATA_W        = 8;

   localparam logic [6:0] OPC_SKIP_EQUAL   = 7'h31;
   localparam logic [6:0] OPC_SKIP_GREATER = 7'h32;
   localparam logic [6:0] OPC_SKIP_LESS    = 7'h30;

   // ************************************************************
   // Fast bank layout.
   // ************************************************************
   localparam logic [FILE_W-1:0] FAST_SPLIT   = 8'h80;
   localparam logic [BANK_W-1:0] FAST_LO_BANK = 4'h0;
   localparam logic [BANK_W-1:0] FAST_HI_BANK = 4'hF;

   // ************************************************************
   // Cycle counts reported per instruction.
   // ************************************************************
   localparam logic [1:0] CYC_NO_SKIP   = 2'h1;
   localparam logic [1:0] CYC_SKIP      = 2'h2;
   localparam logic [1:0] CYC_SKIP_TWO  = 2'h3;

   // ************************************************************
   // Types.
   // ************************************************************
   typedef enum logic [1:0] {
      CMPSKP_OP_NONE    = 2'b00,
      CMPSKP_OP_EQUAL   = 2'b01,
      CMPSKP_OP_GREATER = 2'b10,
      CMPSKP_OP_LESS    = 2'b11
   } cmpskp_op_e;

   typedef enum logic [1:0] {
      CMPSKP_ST_IDLE = 2'b00,
      CMPSKP_ST_READ = 2'b01,
      CMPSKP_ST_NOP1 = 2'b10,
      CMPSKP_ST_NOP2 = 2'b11
   } cmpskp_state_e;

   // Maps an operand to a full data address.
   function automatic logic [ADDR_W-1:0] cmpskp_map_addr(
      input logic              a_bit,
      input logic [FILE_W-1:0] file_addr,
      input logic [BANK_W-1:0] bank_sel
   );
      logic [BANK_W-1:0] bank;
      bank = bank_sel;
      if (!a_bit) begin
         bank = (file_addr < FAST_SPLIT) ? FAST_LO_BANK : FAST_HI_BANK;
      end
      return {bank, file_addr};
   endfunction : cmpskp_map_addr

endpackage : cmpskp_pkg

// [inc/cmpskp_dec_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface cmpskp_dec_if;
   import cmpskp_pkg::*;

   logic [WORD_W-1:0] word;
   cmpskp_op_e        op;
   logic              a_bit;
   logic [FILE_W-1:0] file_addr;

   modport decoder (input word, output op, output a_bit, output file_addr);
   modport user    (output word, input op, input a_bit, input file_addr);

endinterface : cmpskp_dec_if

`default_nettype wire

// [design/cmpskp_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module cmpskp_decode (
   cmpskp_dec_if.decoder dec
);
   import cmpskp_pkg::*;

   // ************************************************************
   // Opcode decode.
   // ************************************************************
   always_comb begin
      case (dec.word[OPC_MSB:OPC_LSB])
         OPC_SKIP_EQUAL:   dec.op = CMPSKP_OP_EQUAL;
         OPC_SKIP_GREATER: dec.op = CMPSKP_OP_GREATER;
         OPC_SKIP_LESS:    dec.op = CMPSKP_OP_LESS;
         default:          dec.op = CMPSKP_OP_NONE;
      endcase
   end

   // Single word carries the operand bit and the full file address.
   assign dec.a_bit     = dec.word[ABIT_POS];
   assign dec.file_addr = dec.word[FILE_MSB:0];

endmodule : cmpskp_decode

`default_nettype wire

// [tb/cmpskp_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module cmpskp_core_sva (
   // Clock and reset.
   input wire logic                          core_clk,
   input wire logic                          rst,
   // Instruction side.
   input wire logic                          instr_valid,
   input wire logic [cmpskp_pkg::WORD_W-1:0] instr_word,
   input wire logic                          instr_ready,
   input wire logic                          cmp_hit,
   input wire logic                          next_two_word,
   input wire logic [cmpskp_pkg::DATA_W-1:0] working_register,
   input wire logic [cmpskp_pkg::BANK_W-1:0] bank_select_register,
   // Memory and results.
   input wire logic                          mem_rd_en,
   input wire logic [cmpskp_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic [cmpskp_pkg::DATA_W-1:0] mem_rd_data,
   input wire logic                          skip_discard,
   input wire logic                          nop_cycle,
   input wire logic                          cmp_done,
   input wire logic [1:0]                    cmp_cycles,
   input wire logic [cmpskp_pkg::DATA_W-1:0] cmp_diff
);
   import cmpskp_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic              take, is_cmp, sk;
   logic [1:0]        op_d, op_q;
   logic [ADDR_W-1:0] ad_d, ad_q;
   assign is_cmp = instr_word[15:9] inside {OPC_SKIP_EQUAL, OPC_SKIP_GREATER, OPC_SKIP_LESS};
   assign take = instr_valid && instr_ready && cmp_hit;
   always_comb begin
      op_d = take ? instr_word[10:9] : op_q;
      ad_d = ad_q;
      if (take) begin
         ad_d[7:0] = instr_word[7:0];
         ad_d[11:8] = instr_word[8] ? bank_select_register :
                      (instr_word[7:0] < 8'h80) ? FAST_LO_BANK : FAST_HI_BANK;
      end
   end
   always_ff @(posedge core_clk) begin
      op_q <= op_d;
      ad_q <= ad_d;
   end
   assign sk = (op_q == 2'b01) ? (mem_rd_data == working_register) :
               (op_q == 2'b10) ? (mem_rd_data > working_register) :
               (mem_rd_data < working_register);
   chk_hit_decode: assert property (
      cmp_hit == (instr_valid && is_cmp))
      else $error("cmp_hit does not match the opcode");
   chk_take_read: assert property (
      take |=> mem_rd_en && !instr_ready)
      else $error("no read after accept");
   chk_no_take: assert property (
      !take |=> !mem_rd_en)
      else $error("read without an accepted compare");
   chk_addr_bank: assert property (
      mem_rd_en |-> mem_rd_addr == ad_q)
      else $error("read address wrong");
   chk_skip_cond: assert property (
      mem_rd_en |=> skip_discard == $past(sk))
      else $error("skip decision wrong");
   chk_diff_value: assert property (
      mem_rd_en |=> cmp_diff == $past(mem_rd_data - working_register))
      else $error("difference wrong");
   chk_no_skip: assert property (
      mem_rd_en && !sk |=> cmp_done && !nop_cycle && cmp_cycles == CYC_NO_SKIP)
      else $error("plain compare timing wrong");
   chk_skip_one: assert property (
      mem_rd_en && sk && !next_two_word |=> nop_cycle ##1
      cmp_done && !nop_cycle && cmp_cycles == CYC_SKIP)
      else $error("single skip timing wrong");
   chk_skip_two: assert property (
      mem_rd_en && sk && next_two_word |=> nop_cycle[*2] ##1
      cmp_done && cmp_cycles == CYC_SKIP_TWO)
      else $error("double skip timing wrong");
   chk_done_ready: assert property (
      cmp_done |-> instr_ready)
      else $error("not idle at the end of a compare");
   cov_plain: cover property (mem_rd_en && !sk);
   cov_skip: cover property (mem_rd_en && sk && !next_two_word);
   cov_two: cover property (mem_rd_en && sk && next_two_word);
   cov_b2b: cover property (cmp_done && take);
endmodule : cmpskp_core_sva
`default_nettype wire

// [tb/cmpskp_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cmpskp_mem_model (
   // Read port.
   input wire logic                          mem_rd_en,
   input wire logic [cmpskp_pkg::ADDR_W-1:0] mem_rd_addr,
   output logic [cmpskp_pkg::DATA_W-1:0]     mem_rd_data
);
   import cmpskp_pkg::*;
   logic [DATA_W-1:0] d;
   // Content pattern; outside a read the port shows the inverse.
   assign d = mem_rd_addr[7:0] ^ {mem_rd_addr[11:8], 4'h0};
   assign mem_rd_data = mem_rd_en ? d : ~d;
endmodule : cmpskp_mem_model
`default_nettype wire

// [tb/cmpskp_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cmpskp_core_tb_top;
   import cmpskp_pkg::*;
   typedef struct packed {
      logic [15:0] w;
      logic [7:0]  off;
      logic [3:0]  b;
      logic        two;
      logic [1:0]  cyc;
   } cmpskp_row_s;
   logic        core_clk = 0, rst = 1, instr_valid = 0, next_two_word = 0;
   logic [15:0] instr_word = 16'h0000;
   logic [7:0]  working_register = 8'h00, mem_rd_data, cmp_diff;
   logic [3:0]  bank_select_register = 4'h0;
   logic        instr_ready, cmp_hit, mem_rd_en, skip_discard, nop_cycle, cmp_done;
   logic [11:0] mem_rd_addr;
   logic [1:0]  cmp_cycles;
   int          fails = 0, compares = 0, n;
   cmpskp_row_s rows [9] = '{
      '{16'h6205, 8'h00, 4'h3, 1'b0, 2'h2}, '{16'h6205, 8'h01, 4'h3, 1'b1, 2'h1},
      '{16'h63FF, 8'h00, 4'h3, 1'b1, 2'h3}, '{16'h6490, 8'hFF, 4'h0, 1'b0, 2'h2},
      '{16'h6490, 8'h00, 4'h0, 1'b0, 2'h1}, '{16'h6500, 8'hFF, 4'hA, 1'b1, 2'h3},
      '{16'h6080, 8'h01, 4'h0, 1'b0, 2'h2}, '{16'h607F, 8'h00, 4'h0, 1'b0, 2'h1},
      '{16'h6110, 8'hF0, 4'h1, 1'b1, 2'h3}};
   cmpskp_core uut (.core_clk, .rst, .instr_valid, .instr_word, .instr_ready, .cmp_hit,
      .next_two_word, .working_register, .bank_select_register, .mem_rd_en, .mem_rd_addr,
      .mem_rd_data, .skip_discard, .nop_cycle, .cmp_done, .cmp_cycles, .cmp_diff);
   cmpskp_mem_model u_mem (.mem_rd_en, .mem_rd_addr, .mem_rd_data);
   always #10 core_clk = ~core_clk;
   task automatic cmp_val(input string nm, input logic [11:0] e, input logic [11:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_val
   task automatic report_and_stop;
      $display("Counts: compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic run_row(input cmpskp_row_s r);
      logic [11:0] ea, sa;
      logic [7:0]  d, w;
      logic        sk;
      int          sc, nc;
      ea = {r.w[8] ? r.b : (r.w[7:0] < 8'h80 ? 4'h0 : 4'hF), r.w[7:0]};
      d = ea[7:0] ^ {ea[11:8], 4'h0};
      w = d + r.off;
      sk = (r.w[10:9] == 2'b01) ? d == w : (r.w[10:9] == 2'b10) ? d > w : d < w;
      @(negedge core_clk);
      instr_valid = 1;
      instr_word = r.w;
      working_register = w;
      bank_select_register = r.b;
      next_two_word = r.two;
      @(negedge core_clk);
      instr_valid = 0;
      sa = 12'h000;
      n = 0;
      sc = 0;
      nc = 0;
      while (cmp_done !== 1'b1 && n < 10) begin
         if (mem_rd_en === 1'b1) sa = mem_rd_addr;
         sc += (skip_discard === 1'b1);
         nc += (nop_cycle === 1'b1);
         n++;
         @(negedge core_clk);
      end
      cmp_val("addr", ea, sa);
      cmp_val("diff", {4'h0, d - w}, {4'h0, cmp_diff});
      cmp_val("span", {10'h000, r.cyc}, n[11:0]);
      cmp_val("cycles", {10'h000, r.cyc}, {10'h000, cmp_cycles});
      cmp_val("skips", {11'h000, sk}, sc[11:0]);
      cmp_val("nops", {10'h000, r.cyc - 2'h1}, nc[11:0]);
   endtask : run_row
   initial begin
      #(20 * 2000);
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (4) @(negedge core_clk);
      rst = 0;
      cmp_val("ready", 12'h001, {11'h000, instr_ready});
      cmp_val("done", 12'h000, {11'h000, cmp_done});
      $display("reset test done");
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("row %0d done", i);
      end
      instr_word = 16'h6A05;
      instr_valid = 1;
      n = 0;
      repeat (3) begin
         @(negedge core_clk);
         n += mem_rd_en + cmp_hit;
      end
      cmp_val("foreign", 12'h000, n[11:0]);
      $display("foreign word test done");
      instr_word = 16'h6205;
      working_register = 8'h05;
      next_two_word = 0;
      n = 0;
      repeat (5) begin
         @(negedge core_clk);
         n += mem_rd_en;
      end
      instr_valid = 0;
      cmp_val("b2b reads", 12'h002, n[11:0]);
      $display("back to back test done");
      repeat (4) @(negedge core_clk);
      instr_word = 16'h6205;
      working_register = 8'h05;
      next_two_word = 1;
      instr_valid = 1;
      @(negedge core_clk);
      instr_valid = 0;
      @(negedge core_clk);
      rst = 1;
      @(negedge core_clk);
      rst = 0;
      cmp_val("reset nop", 12'h000, {11'h000, nop_cycle});
      cmp_val("reset ready", 12'h001, {11'h000, instr_ready});
      @(negedge core_clk);
      cmp_val("reset done", 12'h000, {11'h000, cmp_done});
      $display("mid-run reset test done");
      repeat (2) @(negedge core_clk);
      report_and_stop;
   end
endmodule : cmpskp_core_tb_top
bind cmpskp_core cmpskp_core_sva u_sva (.core_clk, .rst, .instr_valid, .instr_word,
   .instr_ready, .cmp_hit, .next_two_word, .working_register, .bank_select_register,
   .mem_rd_en, .mem_rd_addr, .mem_rd_data, .skip_discard, .nop_cycle, .cmp_done,
   .cmp_cycles, .cmp_diff);
`default_nettype wire
